// *** spi_eeprom_pkg.sv ***
`default_nettype none
package spi_eeprom_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_FREQ_KHZ = 100000;
  localparam int unsigned WRITE_CYCLE_TIME_MS = 10;
  localparam int unsigned WRITE_CYCLE_CNT = WRITE_CYCLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned POWERUP_RESET_TIME_MS = 200;
  localparam int unsigned POWERUP_RESET_CNT = POWERUP_RESET_TIME_MS * CLK_FREQ_KHZ;
  localparam int TIMER_W = 25;

  // Array geometry
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int FIFO_DEPTH = 8;

  // Opcodes
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [3:0] OP_ARRAY_TOP = 4'h0;
  localparam logic [2:0] OP_READ_LOW = 3'h3;
  localparam logic [2:0] OP_WRITE_LOW = 3'h2;
  localparam int OP_ADDR_BIT = 3;

  // Status byte layout
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_WD_LO = 4;
  localparam int ST_WD_HI = 5;
  localparam int ST_NV_LO = 2;
  localparam int ST_NV_HI = 5;
  localparam logic [3:0] NV_RESET = 4'hc;

  // Block protect settings
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [8:0] BP_QUARTER_BASE = 9'h180;
  localparam logic [8:0] BP_HALF_BASE = 9'h100;

  // Bit and page counter limits
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] PAGE_LAST = 4'hf;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } link_pins_t;

  localparam link_pins_t PINS_RESET = '0;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } wr_entry_t;

  typedef enum logic [3:0] {
    LS_IDLE,
    LS_OPCODE,
    LS_WEL_CMD,
    LS_ADDR,
    LS_RD_ARRAY,
    LS_RD_STATUS,
    LS_WR_STATUS,
    LS_WR_DATA,
    LS_IGNORE
  } link_state_t;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_FILL,
    ENG_WAIT
  } engine_state_t;

endpackage : spi_eeprom_pkg
`default_nettype wire

// *** write_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module write_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0] wr_ptr_reg;
  logic [PTR_W:0] wr_ptr_next;
  logic [PTR_W:0] rd_ptr_reg;
  logic [PTR_W:0] rd_ptr_next;
  logic full;
  logic empty;
  logic push;
  logic pop;

  always_comb
  begin
    empty = (wr_ptr_reg == rd_ptr_reg);
    full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
           (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
    push = i_in_valid && !full;
    pop = i_out_ready && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage, no reset
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      store[wr_ptr_reg[PTR_W-1:0]] <= i_in_data;
    end
  end

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = store[rd_ptr_reg[PTR_W-1:0]];

endmodule : write_fifo
`default_nettype wire

// *** spi_eeprom_access.sv ***
// Contract
// - Status read: opcode, then status byte out
// - Status read works during nonvolatile write
// - Status write: opcode plus exactly 8 bits
// - Write enable latch set in separate transaction
// - No deselect after enable: status write ignored
// - No deselect after enable: array write ignored
// - Writes need latch set and protect pin high
// - Array read: opcode bit 3, 8-bit address
// - Read address increments after each byte
// - Read address wraps to zero past top
// - Deselect ends read, output released
// - Array write: opcode, address, then data bytes
// - One write holds 1 to 16 bytes, one page
// - Page address wraps within page, overwriting
// - Commit only on deselect at byte boundary
// - Busy flag high for whole nonvolatile write
// - Power-up: instruction only after select falls
// - Power-up: output released, latch cleared, flag cleared
// - Power-up: reset output held for timeout
// - Protect pin low blocks all nonvolatile writes
// - Fixed opcode encodings, sent MSB first
// - Array opcodes carry ninth address bit
// - Status byte layout, top bits read zero
// - Sample on rising, drive on falling, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_access #(
  parameter int unsigned WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_CNT,
  parameter int unsigned POWERUP_CYCLES = spi_eeprom_pkg::POWERUP_RESET_CNT
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Link pins to and from the host
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  // Supervisor and status
  output logic o_sys_reset,
  output logic o_write_in_progress,
  output logic [1:0] o_watchdog_sel
);
  import spi_eeprom_pkg::*;

  // Pin synchronisers
  link_pins_t pins_in;
  link_pins_t pins_meta_reg;
  link_pins_t pins_sync_reg;
  link_pins_t pins_prev_reg;

  // Link state
  link_state_t link_state_reg;
  link_state_t link_state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [2:0] tx_cnt_reg;
  logic [2:0] tx_cnt_next;
  logic so_reg;
  logic so_next;
  logic [8:0] addr_reg;
  logic [8:0] addr_next;
  logic is_write_reg;
  logic is_write_next;
  logic [7:0] stat_data_reg;
  logic [7:0] stat_data_next;
  logic stat_done_reg;
  logic stat_done_next;
  logic byte_seen_reg;
  logic byte_seen_next;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [PAGE_BYTES-1:0] mask_next;
  logic [3:0] nv_reg;
  logic [3:0] nv_next;
  logic wel_reg;
  logic wel_next;

  // Write engine state
  engine_state_t eng_reg;
  engine_state_t eng_next;
  logic [PAGE_W-1:0] idx_reg;
  logic [PAGE_W-1:0] idx_next;
  logic [4:0] page_base_reg;
  logic [4:0] page_base_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic pace_reg;
  logic pace_next;

  // Power-up reset state
  logic [TIMER_W-1:0] por_cnt_reg;
  logic [TIMER_W-1:0] por_cnt_next;
  logic sys_reset_reg;
  logic sys_reset_next;

  // Combinational helpers
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic selected;
  logic busy;
  logic write_ok;
  logic [7:0] byte_in;
  logic [7:0] status_byte;
  logic wel_set;
  logic wel_clr;
  logic start_array;
  logic start_status;
  logic eng_done;
  logic pbuf_we;
  logic [PAGE_W-1:0] pbuf_wa;
  logic [7:0] pbuf_wd;
  logic [8:0] fill_addr;
  wr_entry_t push_data;
  logic push_valid;
  logic push_ready;
  wr_entry_t pop_data;
  logic pop_valid;
  logic pop_ready;

  // Array and page buffer
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] pbuf [PAGE_BYTES];

  function automatic logic is_protected(input logic [8:0] a, input logic [1:0] bp);
    logic prot;
    prot = 1'b1;
    case (bp)
      BP_NONE: prot = 1'b0;
      BP_QUARTER: prot = (a >= BP_QUARTER_BASE);
      BP_HALF: prot = (a >= BP_HALF_BASE);
      default: prot = 1'b1;
    endcase
    return prot;
  endfunction : is_protected

  assign pins_in = '{cs_n: i_cs_n, sck: i_sck, si: i_si, wp_n: i_wp_n};

  // Two-stage synchroniser, then edge history
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pins_meta_reg <= PINS_RESET;
      pins_sync_reg <= PINS_RESET;
      pins_prev_reg <= PINS_RESET;
    end
    else
    begin
      pins_meta_reg <= pins_in;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  always_comb
  begin
    // Select treated as already low at reset release
    cs_fall = pins_prev_reg.cs_n && !pins_sync_reg.cs_n;
    cs_rise = !pins_prev_reg.cs_n && pins_sync_reg.cs_n;
    sck_rise = !pins_prev_reg.sck && pins_sync_reg.sck;
    sck_fall = pins_prev_reg.sck && !pins_sync_reg.sck;
    selected = !pins_sync_reg.cs_n;
    busy = (eng_reg != ENG_IDLE);
    write_ok = wel_reg && pins_sync_reg.wp_n && !busy;
    byte_in = {shift_reg[6:0], pins_sync_reg.si};
    status_byte = 8'h00;
    status_byte[ST_WIP] = busy;
    status_byte[ST_WEL] = wel_reg;
    status_byte[ST_BP_HI:ST_BP_LO] = nv_reg[1:0];
    status_byte[ST_WD_HI:ST_WD_LO] = nv_reg[3:2];
  end

  // Link next-state logic
  always_comb
  begin
    link_state_next = link_state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    tx_cnt_next = tx_cnt_reg;
    so_next = so_reg;
    addr_next = addr_reg;
    is_write_next = is_write_reg;
    stat_data_next = stat_data_reg;
    stat_done_next = stat_done_reg;
    byte_seen_next = byte_seen_reg;
    mask_next = mask_reg;
    nv_next = nv_reg;
    wel_set = 1'b0;
    wel_clr = 1'b0;
    start_array = 1'b0;
    start_status = 1'b0;
    pbuf_we = 1'b0;
    pbuf_wa = addr_reg[PAGE_W-1:0];
    pbuf_wd = byte_in;
    if (cs_rise)
    begin
      case (link_state_reg)
        LS_WEL_CMD:
        begin
          // Latch changes only once the enable transaction closes
          if (bit_cnt_reg == BIT_FIRST && shift_reg == OP_SET_WEL)
            wel_set = 1'b1;
          if (bit_cnt_reg == BIT_FIRST && shift_reg == OP_CLR_WEL)
            wel_clr = 1'b1;
        end
        LS_WR_STATUS:
        begin
          if (stat_done_reg && bit_cnt_reg == BIT_FIRST && write_ok)
          begin
            nv_next = stat_data_reg[ST_NV_HI:ST_NV_LO];
            start_status = 1'b1;
          end
        end
        LS_WR_DATA:
        begin
          if (byte_seen_reg && bit_cnt_reg == BIT_FIRST && write_ok)
            start_array = 1'b1;
        end
        default:
        begin
        end
      endcase
      link_state_next = LS_IDLE;
    end
    else if (cs_fall)
    begin
      link_state_next = LS_OPCODE;
      bit_cnt_next = BIT_FIRST;
    end
    else if (selected && sck_rise)
    begin
      shift_next = byte_in;
      bit_cnt_next = bit_cnt_reg + 3'h1;
      case (link_state_reg)
        LS_OPCODE:
        begin
          if (bit_cnt_reg == BIT_LAST)
          begin
            tx_cnt_next = BIT_FIRST;
            stat_done_next = 1'b0;
            if (byte_in == OP_SET_WEL || byte_in == OP_CLR_WEL)
              link_state_next = LS_WEL_CMD;
            else if (byte_in == OP_RD_STATUS)
            begin
              link_state_next = LS_RD_STATUS;
              tx_next = status_byte;
            end
            else if (byte_in == OP_WR_STATUS)
              link_state_next = (wel_reg && !busy) ? LS_WR_STATUS : LS_IGNORE;
            else if (byte_in[7:4] == OP_ARRAY_TOP && byte_in[2:0] == OP_READ_LOW && !busy)
            begin
              link_state_next = LS_ADDR;
              is_write_next = 1'b0;
              addr_next[ADDR_W-1] = byte_in[OP_ADDR_BIT];
            end
            else if (byte_in[7:4] == OP_ARRAY_TOP && byte_in[2:0] == OP_WRITE_LOW &&
                     wel_reg && !busy)
            begin
              link_state_next = LS_ADDR;
              is_write_next = 1'b1;
              addr_next[ADDR_W-1] = byte_in[OP_ADDR_BIT];
            end
            else
              link_state_next = LS_IGNORE;
          end
        end
        LS_WEL_CMD:
          link_state_next = LS_IGNORE;
        LS_ADDR:
        begin
          if (bit_cnt_reg == BIT_LAST)
          begin
            addr_next = {addr_reg[ADDR_W-1], byte_in};
            byte_seen_next = 1'b0;
            mask_next = '0;
            if (is_write_reg)
              link_state_next = LS_WR_DATA;
            else
            begin
              link_state_next = LS_RD_ARRAY;
              tx_next = mem[{addr_reg[ADDR_W-1], byte_in}];
            end
          end
        end
        LS_WR_STATUS:
        begin
          if (stat_done_reg)
            link_state_next = LS_IGNORE;
          else if (bit_cnt_reg == BIT_LAST)
          begin
            stat_data_next = byte_in;
            stat_done_next = 1'b1;
          end
        end
        LS_WR_DATA:
        begin
          if (bit_cnt_reg == BIT_LAST)
          begin
            pbuf_we = 1'b1;
            mask_next[addr_reg[PAGE_W-1:0]] = 1'b1;
            byte_seen_next = 1'b1;
            addr_next[PAGE_W-1:0] = addr_reg[PAGE_W-1:0] + 4'h1;
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (selected && sck_fall &&
             (link_state_reg == LS_RD_ARRAY || link_state_reg == LS_RD_STATUS))
    begin
      so_next = tx_reg[7];
      tx_next = {tx_reg[6:0], 1'b0};
      tx_cnt_next = tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == BIT_LAST)
      begin
        if (link_state_reg == LS_RD_ARRAY)
        begin
          addr_next = addr_reg + 9'h001;
          tx_next = mem[addr_reg + 9'h001];
        end
        else
          tx_next = status_byte;
      end
    end
  end

  // Write engine next-state logic
  always_comb
  begin
    eng_next = eng_reg;
    idx_next = idx_reg;
    page_base_next = page_base_reg;
    timer_next = timer_reg;
    eng_done = 1'b0;
    pace_next = busy ? !pace_reg : 1'b0;
    fill_addr = {page_base_reg, idx_reg};
    push_data = '{addr: fill_addr, data: pbuf[idx_reg]};
    push_valid = (eng_reg == ENG_FILL) && mask_reg[idx_reg] &&
                 !is_protected(fill_addr, nv_reg[1:0]);
    pop_ready = pace_reg;
    if (busy && timer_reg != TIMER_W'(WRITE_CYCLES - 1))
      timer_next = timer_reg + 1'b1;
    case (eng_reg)
      ENG_IDLE:
      begin
        timer_next = '0;
        idx_next = '0;
        page_base_next = addr_reg[ADDR_W-1:PAGE_W];
        if (start_array)
          eng_next = ENG_FILL;
        else if (start_status)
          eng_next = ENG_WAIT;
      end
      ENG_FILL:
      begin
        if (!push_valid || push_ready)
        begin
          idx_next = idx_reg + 4'h1;
          if (idx_reg == PAGE_LAST)
            eng_next = ENG_WAIT;
        end
      end
      ENG_WAIT:
      begin
        if (timer_reg == TIMER_W'(WRITE_CYCLES - 1) && !pop_valid)
        begin
          eng_next = ENG_IDLE;
          eng_done = 1'b1;
        end
      end
      default:
        eng_next = ENG_IDLE;
    endcase
  end

  // Latch and power-up reset next values
  always_comb
  begin
    wel_next = wel_reg;
    if (wel_clr || eng_done || !pins_sync_reg.wp_n)
      wel_next = 1'b0;
    if (wel_set && pins_sync_reg.wp_n)
      wel_next = 1'b1;
    por_cnt_next = por_cnt_reg;
    sys_reset_next = sys_reset_reg;
    if (sys_reset_reg)
    begin
      por_cnt_next = por_cnt_reg + 1'b1;
      if (por_cnt_reg == TIMER_W'(POWERUP_CYCLES - 1))
        sys_reset_next = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      link_state_reg <= LS_IDLE;
      bit_cnt_reg <= BIT_FIRST;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      tx_cnt_reg <= BIT_FIRST;
      so_reg <= 1'b0;
      addr_reg <= 9'h000;
      is_write_reg <= 1'b0;
      stat_data_reg <= 8'h00;
      stat_done_reg <= 1'b0;
      byte_seen_reg <= 1'b0;
      mask_reg <= '0;
      nv_reg <= NV_RESET;
      wel_reg <= 1'b0;
      eng_reg <= ENG_IDLE;
      idx_reg <= '0;
      page_base_reg <= '0;
      timer_reg <= '0;
      pace_reg <= 1'b0;
      por_cnt_reg <= '0;
      sys_reset_reg <= 1'b1;
    end
    else
    begin
      link_state_reg <= link_state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      tx_cnt_reg <= tx_cnt_next;
      so_reg <= so_next;
      addr_reg <= addr_next;
      is_write_reg <= is_write_next;
      stat_data_reg <= stat_data_next;
      stat_done_reg <= stat_done_next;
      byte_seen_reg <= byte_seen_next;
      mask_reg <= mask_next;
      nv_reg <= nv_next;
      wel_reg <= wel_next;
      eng_reg <= eng_next;
      idx_reg <= idx_next;
      page_base_reg <= page_base_next;
      timer_reg <= timer_next;
      pace_reg <= pace_next;
      por_cnt_reg <= por_cnt_next;
      sys_reset_reg <= sys_reset_next;
    end
  end

  // Page buffer and array storage
  always_ff @(posedge i_mclk)
  begin
    if (pbuf_we)
      pbuf[pbuf_wa] <= pbuf_wd;
    if (pop_valid && pop_ready)
      mem[pop_data.addr] <= pop_data.data;
  end

  // Paced commit queue between page buffer and array
  write_fifo #(
    .WIDTH($bits(wr_entry_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_data)
  );

  assign o_so = so_reg;
  assign o_so_oe = (link_state_reg == LS_RD_ARRAY) || (link_state_reg == LS_RD_STATUS);
  assign o_sys_reset = sys_reset_reg;
  assign o_write_in_progress = busy;
  assign o_watchdog_sel = nv_reg[3:2];

endmodule : spi_eeprom_access
`default_nettype wire

// *** spi_eeprom_access_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_access_monitor #(
  parameter int unsigned WRITE_CYCLES = 1000,
  parameter int unsigned POWERUP_CYCLES = 50
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Watched pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_sys_reset,
  input wire logic o_write_in_progress,
  input wire logic [1:0] o_watchdog_sel
);
  logic [31:0] up_cnt_reg;
  logic [31:0] up_cnt_next;
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // Cycles since reset and length of busy run
  always_comb
  begin
    up_cnt_next = (up_cnt_reg < POWERUP_CYCLES + 8) ? up_cnt_reg + 32'h1 : up_cnt_reg;
    busy_cnt_next = o_write_in_progress ? busy_cnt_reg + 32'h1 : 32'h0;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      up_cnt_reg <= 32'h0;
      busy_cnt_reg <= 32'h0;
    end
    else
    begin
      up_cnt_reg <= up_cnt_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  chk_reset_hold: assert property (up_cnt_reg < POWERUP_CYCLES |-> o_sys_reset)
    else $error("Reset output dropped early");
  chk_reset_drop: assert property (up_cnt_reg > POWERUP_CYCLES + 4 |-> !o_sys_reset)
    else $error("Reset output held too long");
  chk_busy_min: assert property
    ($fell(o_write_in_progress) |-> busy_cnt_reg >= WRITE_CYCLES - 1)
    else $error("Busy flag too short");
  chk_busy_max: assert property (busy_cnt_reg <= WRITE_CYCLES + 64)
    else $error("Busy flag too long");
  chk_busy_start: assert property ($rose(o_write_in_progress) |-> i_cs_n)
    else $error("Write started while selected");
  chk_busy_protect: assert property (!i_wp_n [*8] |=> !$rose(o_write_in_progress))
    else $error("Write started with protect low");
  chk_wd_update: assert property
    ($changed(o_watchdog_sel) |-> i_cs_n && i_wp_n)
    else $error("Watchdog bits changed unexpectedly");
  chk_out_release: assert property ($rose(i_cs_n) |-> ##[1:5] !o_so_oe)
    else $error("Output not released after deselect");
  chk_out_idle: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("Output driven while deselected");
  chk_out_select: assert property ($rose(o_so_oe) |-> !i_cs_n)
    else $error("Output enabled without select");
  chk_so_edge: assert property
    (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck, 2))
    else $error("Output bit changed off the falling edge");
endmodule : spi_eeprom_access_monitor

bind spi_eeprom_access spi_eeprom_access_monitor #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .POWERUP_CYCLES(POWERUP_CYCLES)
) mon (
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_cs_n(i_cs_n),
  .i_sck(i_sck),
  .i_wp_n(i_wp_n),
  .o_so(o_so),
  .o_so_oe(o_so_oe),
  .o_sys_reset(o_sys_reset),
  .o_write_in_progress(o_write_in_progress),
  .o_watchdog_sel(o_watchdog_sel)
);
`default_nettype wire

// *** spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock
  input wire logic i_mclk,
  // Link pins
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  logic [7:0] tx_buf [0:31];
  logic [7:0] rx_buf [0:31];
  logic framing;

  initial
  begin
    framing = 1'b0;
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end

  // Data line toggles between frames; run also toggles it during receive bits
  always @(posedge i_mclk)
  begin
    if (o_cs_n && !framing)
    begin
      o_si <= ~o_si;
    end
  end

  // One framed transfer: n_tx bits sent, then n_rx bits taken
  task automatic run(input int n_tx, input int n_rx);
    int i;
    int k;
    framing = 1'b1;
    repeat (4) @(posedge i_mclk);
    o_cs_n <= 1'b0;
    for (i = 0; i < n_tx + n_rx; i++)
    begin
      k = (i < n_tx) ? i : i - n_tx;
      o_si <= (i < n_tx) ? tx_buf[k / 8][7 - k % 8] : ~o_si;
      repeat (8) @(posedge i_mclk);
      o_sck <= 1'b1;
      if (i >= n_tx)
      begin
        rx_buf[k / 8][7 - k % 8] = i_so;
      end
      repeat (8) @(posedge i_mclk);
      o_sck <= 1'b0;
    end
    repeat (8) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_mclk);
    framing = 1'b0;
  endtask : run
endmodule : spi_host_model
`default_nettype wire

// *** tb_spi_eeprom_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_spi_eeprom_access;
  import spi_eeprom_pkg::*;
  localparam int unsigned WC = 1000;
  localparam int unsigned PC = 50;
  logic i_mclk;
  logic i_arst_n;
  logic i_wp_n;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic sys_reset;
  logic write_in_progress;
  logic [1:0] wd_sel;
  logic [7:0] mem [0:511];
  logic [8:0] a;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 74;
  int r;

  spi_host_model host (
    .i_mclk(i_mclk),
    .i_so(so_oe ? so : ~so),
    .o_cs_n(cs_n),
    .o_sck(sck),
    .o_si(si)
  );

  spi_eeprom_access #(.WRITE_CYCLES(WC), .POWERUP_CYCLES(PC)) uut (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_cs_n(cs_n),
    .i_sck(sck),
    .i_si(si),
    .i_wp_n(i_wp_n),
    .o_so(so),
    .o_so_oe(so_oe),
    .o_sys_reset(sys_reset),
    .o_write_in_progress(write_in_progress),
    .o_watchdog_sel(wd_sel)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  function automatic logic [7:0] status_exp(input logic write_enable_latch, input logic [3:0] nv);
    return {2'b00, nv, write_enable_latch, 1'b0};
  endfunction : status_exp

  task automatic cmd(input logic [7:0] op);
    host.tx_buf[0] = op;
    host.run(8, 0);
  endtask : cmd

  task automatic read_status_cmd(input logic [7:0] exp);
    host.tx_buf[0] = OP_RD_STATUS;
    host.run(8, 8);
    check("status", exp, host.rx_buf[0]);
  endtask : read_status_cmd

  // Array write; lands marks bytes the array should keep
  task automatic wr(input logic [8:0] ad, input int n, input int bits, input bit lands);
    int j;
    host.tx_buf[0] = {OP_ARRAY_TOP, ad[8], OP_WRITE_LOW};
    host.tx_buf[1] = ad[7:0];
    for (j = 0; j < n; j++)
    begin
      host.tx_buf[2 + j] = 8'($random(seed));
      if (lands)
      begin
        mem[{ad[8:4], 4'(ad[3:0] + j)}] = host.tx_buf[2 + j];
      end
    end
    host.run(bits, 0);
  endtask : wr

  task automatic rd(input logic [8:0] ad, input int n);
    int j;
    host.tx_buf[0] = {OP_ARRAY_TOP, ad[8], OP_READ_LOW};
    host.tx_buf[1] = ad[7:0];
    host.run(16, 8 * n);
    for (j = 0; j < n; j++)
    begin
      check("array byte", mem[9'(ad + j)], host.rx_buf[j]);
    end
  endtask : rd

  task automatic wait_idle;
    int t;
    t = 0;
    while (write_in_progress !== 1'b0 && t < 3000)
    begin
      @(posedge i_mclk);
      t++;
    end
    check("busy flag", 8'h0, {7'h0, write_in_progress});
  endtask : wait_idle

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (90000) @(posedge i_mclk);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    i_arst_n = 1'b0;
    i_wp_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    check("power-up outputs", 8'h0b, {4'h0, sys_reset, so_oe, wd_sel});
    repeat (PC + 8) @(posedge i_mclk);
    check("reset output", 8'h0, {7'h0, sys_reset});
    read_status_cmd(status_exp(1'b0, NV_RESET));
    cmd(OP_SET_WEL);
    read_status_cmd(status_exp(1'b1, NV_RESET));
    cmd(OP_CLR_WEL);
    read_status_cmd(status_exp(1'b0, NV_RESET));
    for (r = 0; r < 2; r++)
    begin
      a = 9'($random(seed));
      cmd(OP_SET_WEL);
      wr(a, 18, 16 + 8 * 18, 1'b1);
      read_status_cmd(status_exp(1'b1, NV_RESET) | 8'h01);
      wait_idle();
      read_status_cmd(status_exp(1'b0, NV_RESET));
      rd({a[8:4], 4'h0}, 16);
    end
    cmd(OP_SET_WEL);
    wr(9'h1ff, 1, 24, 1'b1);
    wait_idle();
    cmd(OP_SET_WEL);
    wr(9'h000, 1, 24, 1'b1);
    wait_idle();
    rd(9'h1ff, 2);
    host.tx_buf[0] = OP_SET_WEL;
    host.tx_buf[1] = OP_WR_STATUS;
    host.tx_buf[2] = 8'h00;
    host.run(24, 0);
    read_status_cmd(status_exp(1'b0, NV_RESET));
    host.tx_buf[1] = {OP_ARRAY_TOP, 1'b0, OP_WRITE_LOW};
    host.tx_buf[3] = ~mem[0];
    host.run(32, 0);
    rd(9'h000, 1);
    cmd(OP_SET_WEL);
    wr(9'h000, 1, 28, 1'b0);
    repeat (20) @(posedge i_mclk);
    check("aborted busy", 8'h0, {7'h0, write_in_progress});
    rd(9'h000, 1);
    cmd(OP_CLR_WEL);
    i_wp_n <= 1'b0;
    cmd(OP_SET_WEL);
    wr(9'h000, 1, 24, 1'b0);
    repeat (20) @(posedge i_mclk);
    check("protected busy", 8'h0, {7'h0, write_in_progress});
    rd(9'h000, 1);
    read_status_cmd(status_exp(1'b0, NV_RESET));
    i_wp_n <= 1'b1;
    cmd(OP_SET_WEL);
    host.tx_buf[0] = OP_WR_STATUS;
    host.tx_buf[1] = 8'hcb;
    host.run(16, 0);
    wait_idle();
    check("watchdog bits", 8'h0, {6'h0, wd_sel});
    read_status_cmd(status_exp(1'b0, 4'h2));
    cmd(OP_SET_WEL);
    wr(9'h1ff, 1, 24, 1'b0);
    wait_idle();
    rd(9'h1ff, 1);
    cmd(OP_SET_WEL);
    host.tx_buf[0] = OP_WR_STATUS;
    host.tx_buf[1] = 8'h04;
    host.run(16, 0);
    wait_idle();
    read_status_cmd(status_exp(1'b0, 4'h1));
    cmd(OP_SET_WEL);
    wr(9'h17f, 1, 24, 1'b1);
    wait_idle();
    cmd(OP_SET_WEL);
    wr(9'h180, 1, 24, 1'b0);
    wait_idle();
    rd(9'h17f, 2);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (5) @(posedge i_mclk);
    check("watchdog after reset", 8'h3, {6'h0, wd_sel});
    read_status_cmd(status_exp(1'b0, NV_RESET));
    tally_and_finish();
  end
endmodule : tb_spi_eeprom_access
`default_nettype wire
